// File: hw/clk_sel_pkg.sv
// constants, register map and encodings of the clock source selection unit
// Notes on behaviour
// - cpu starts on internal high-speed clock
// - main crystal stops on stop or software
// - internal high-speed osc stops likewise
// - external main clock gated on stop or software
// - main clock picks high-speed or internal
// - sub crystal run by start bit and modes
// - sub external input set by same bits
// - low-speed osc always runs after reset
// - low-speed stop only when option permits
// - low-speed clock never feeds the cpu
// - mode register byte writable, resets 00H
// - bits 7:6 choose high-speed pin mode
// - bit 0 sets oscillator gain range
// - sub pin mode from start bit, bits 5:4
// - gain set by first mode write only; external clock halts 160
package clk_sel_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_PIN_MODE = 8'h00;
    localparam logic [7:0] ADDR_PROC_CLK = 8'h04;
    localparam logic [7:0] ADDR_INT_OSC = 8'h08;
    localparam logic [7:0] ADDR_MAIN_OSC = 8'h0C;
    localparam logic [7:0] ADDR_MAIN_MODE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // values after reset
    localparam logic [7:0] RST_PIN_MODE = 8'h00;
    localparam logic [7:0] RST_PROC_CLK = 8'h01;
    localparam logic [7:0] RST_INT_OSC = 8'h00;
    localparam logic [7:0] RST_MAIN_OSC = 8'h80;
    localparam logic [7:0] RST_MAIN_MODE = 8'h00;
    // field positions in clock_pin_mode_select
    localparam int HS_EXT_BIT = 7;
    localparam int HS_OSC_BIT = 6;
    localparam int SUB_EXT_BIT = 5;
    localparam int SUB_OSC_BIT = 4;
    localparam int GAIN_BIT = 0;
    localparam logic [7:0] PIN_MODE_WMASK = 8'hF1;
    // field positions in processor_clock_control
    localparam int SUB_START_BIT = 6;
    localparam int CPU_STATUS_BIT = 5;
    localparam int CPU_SUB_SEL_BIT = 4;
    localparam logic [7:0] PROC_CLK_WMASK = 8'h57;
    // field positions in internal_osc_mode
    localparam int HS_INT_STOP_BIT = 0;
    localparam int LS_STOP_BIT = 1;
    localparam int EXT_MAIN_DIS_BIT = 2;
    localparam logic [7:0] INT_OSC_WMASK = 8'h07;
    // field positions in main_osc_control and main_clock_mode
    localparam int MAIN_STOP_BIT = 7;
    localparam logic [7:0] MAIN_OSC_WMASK = 8'h80;
    localparam int MAIN_SEL_HS_BIT = 0;
    localparam logic [7:0] MAIN_MODE_WMASK = 8'h01;
    // gain change halt, counted in external clock cycles
    localparam int GAIN_HOLD_EXT_CYCLES = 160;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // pin modes of the high-speed and subsystem pins
    typedef enum logic [1:0] {
        PIN_PORT = 2'b00,
        PIN_RESONATOR = 2'b01,
        PIN_EXT_CLOCK = 2'b11
    } pin_mode_e;
    // cpu clock sources; the low-speed clock has no code
    typedef enum logic [1:0] {
        CPU_HS_INTERNAL = 2'b00,
        CPU_HS_SYSTEM = 2'b01,
        CPU_SUBSYSTEM = 2'b10
    } cpu_src_e;
endpackage

// File: hw/pin_mode_decode.sv
// decodes the oscillator pin modes from the mode select bits
`timescale 1ns/1ps
`default_nettype none
module pin_mode_decode (
    // control bits
    input wire logic hs_ext_in,
    input wire logic hs_osc_in,
    input wire logic sub_ext_in,
    input wire logic sub_osc_in,
    input wire logic sub_start_in,
    // decoded modes
    output clk_sel_pkg::pin_mode_e hs_mode_out,
    output clk_sel_pkg::pin_mode_e sub_mode_out
);
    // high-speed pins: 00 and 10 port, 01 resonator, 11 external clock
    always_comb begin
        if (!hs_osc_in) begin
            hs_mode_out = clk_sel_pkg::PIN_PORT;
        end else if (hs_ext_in) begin
            hs_mode_out = clk_sel_pkg::PIN_EXT_CLOCK;
        end else begin
            hs_mode_out = clk_sel_pkg::PIN_RESONATOR;
        end
    end
    // subsystem pins: start bit forces crystal, else same table
    always_comb begin
        if (sub_start_in) begin
            sub_mode_out = clk_sel_pkg::PIN_RESONATOR;
        end else if (!sub_osc_in) begin
            sub_mode_out = clk_sel_pkg::PIN_PORT;
        end else if (sub_ext_in) begin
            sub_mode_out = clk_sel_pkg::PIN_EXT_CLOCK;
        end else begin
            sub_mode_out = clk_sel_pkg::PIN_RESONATOR;
        end
    end
endmodule
`default_nettype wire

// File: hw/ext_edge_hold.sv
// holds a busy level for a number of rising edges of an external clock pin
`timescale 1ns/1ps
`default_nettype none
module ext_edge_hold #(
    parameter int EDGES = clk_sel_pkg::GAIN_HOLD_EXT_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // asynchronous external clock pin and start pulse
    input wire logic ext_pin_in,
    input wire logic start_in,
    // busy while edges are counted
    output logic busy_out
);
    localparam int CW = $clog2(EDGES + 1);
    logic sync1_r; // first synchroniser stage
    logic sync2_r; // second synchroniser stage
    logic prev_r; // last sampled level for edge detection
    logic [CW-1:0] cnt_r; // edges still to wait
    logic [CW-1:0] cnt_nxt;
    logic rise; // rising edge seen on the pin
    assign rise = sync2_r && !prev_r;
    assign busy_out = (cnt_r != '0);
    // reload on start, count down on each edge
    always_comb begin
        cnt_nxt = cnt_r;
        if (start_in) begin
            cnt_nxt = CW'(EDGES);
        end else if (rise && (cnt_r != '0)) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end
    // synchroniser and counter registers
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            sync1_r <= ext_pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// File: hw/clock_source_select_unit.sv
// clock source selection unit with its axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
module clock_source_select_unit #(
    parameter int GAIN_HOLD_EDGES = clk_sel_pkg::GAIN_HOLD_EXT_CYCLES
) (
    // clock and synchronous reset
    input wire logic CLK_SYS_IN,
    input wire logic SRST_IN,
    // axi4-lite write address
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [7:0] S_AXI_AWADDR_IN,
    // axi4-lite write data
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    // axi4-lite write response
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    output logic [1:0] S_AXI_BRESP_OUT,
    // axi4-lite read address
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    input wire logic [7:0] S_AXI_ARADDR_IN,
    // axi4-lite read data
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    // cpu and option byte levels, same clock
    input wire logic STOP_MODE_IN,
    input wire logic LS_SW_STOP_PERMIT_IN,
    // external high-speed clock pin, asynchronous
    input wire logic EXT_MAIN_CLK_IN,
    // oscillator enables
    output logic MAIN_XTAL_EN_OUT,
    output logic HS_INT_OSC_EN_OUT,
    output logic EXT_MAIN_GATE_EN_OUT,
    output logic SUB_XTAL_EN_OUT,
    output logic SUB_EXT_GATE_EN_OUT,
    output logic LS_OSC_EN_OUT,
    // pin modes and gain
    output logic [1:0] HS_PIN_MODE_OUT,
    output logic [1:0] SUB_PIN_MODE_OUT,
    output logic OSC_GAIN_HIGH_OUT,
    // cpu clock selection
    output logic [1:0] CPU_CLK_SRC_OUT,
    output logic [2:0] CPU_CLK_DIV_OUT,
    output logic CPU_CLK_HOLD_OUT
);
    // software registers
    logic [7:0] pin_mode_r; // clock_pin_mode_select
    logic [7:0] pin_mode_nxt;
    logic [7:0] proc_clk_r; // processor_clock_control
    logic [7:0] proc_clk_nxt;
    logic [7:0] int_osc_r; // internal_osc_mode
    logic [7:0] int_osc_nxt;
    logic [7:0] main_osc_r; // main_osc_control
    logic [7:0] main_osc_nxt;
    logic [7:0] main_mode_r; // main_clock_mode
    logic [7:0] main_mode_nxt;
    logic gain_used_r; // gain already written since reset
    logic gain_used_nxt;
    // bus state
    logic aw_held_r; // write address captured
    logic aw_held_nxt;
    logic w_held_r; // write data captured
    logic w_held_nxt;
    logic [7:0] waddr_r;
    logic [7:0] waddr_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;
    logic wlane_r; // low byte lane was strobed
    logic wlane_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    // output registers
    logic [1:0] cpu_src_r;
    logic [1:0] cpu_src_nxt;
    // decoded helpers
    logic do_write; // both halves of a write are held
    logic gain_start; // gain raised while cpu on external clock
    logic hold_busy; // cpu clock halted for gain change
    logic ls_stop_ok; // software stop of low-speed osc allowed
    clk_sel_pkg::pin_mode_e hs_mode;
    clk_sel_pkg::pin_mode_e sub_mode;

    // true for addresses that hold a register
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == clk_sel_pkg::ADDR_PIN_MODE) ||
            (a == clk_sel_pkg::ADDR_PROC_CLK) ||
            (a == clk_sel_pkg::ADDR_INT_OSC) ||
            (a == clk_sel_pkg::ADDR_MAIN_OSC) ||
            (a == clk_sel_pkg::ADDR_MAIN_MODE) ||
            (a == clk_sel_pkg::ADDR_STATUS);
    endfunction

    // pin mode decoding
    pin_mode_decode u_decode (
        .hs_ext_in(pin_mode_r[clk_sel_pkg::HS_EXT_BIT]),
        .hs_osc_in(pin_mode_r[clk_sel_pkg::HS_OSC_BIT]),
        .sub_ext_in(pin_mode_r[clk_sel_pkg::SUB_EXT_BIT]),
        .sub_osc_in(pin_mode_r[clk_sel_pkg::SUB_OSC_BIT]),
        .sub_start_in(proc_clk_r[clk_sel_pkg::SUB_START_BIT]),
        .hs_mode_out(hs_mode),
        .sub_mode_out(sub_mode)
    );

    // counts external clock edges while the cpu clock is halted
    ext_edge_hold #(
        .EDGES(GAIN_HOLD_EDGES)
    ) u_hold (
        .clk_in(CLK_SYS_IN),
        .srst_in(SRST_IN),
        .ext_pin_in(EXT_MAIN_CLK_IN),
        .start_in(gain_start),
        .busy_out(hold_busy)
    );

    assign do_write = aw_held_r && w_held_r;
    assign ls_stop_ok = LS_SW_STOP_PERMIT_IN && int_osc_r[clk_sel_pkg::LS_STOP_BIT];

    // gain raise that halts the cpu: first gain write, 0 to 1, into external clock mode
    always_comb begin
        gain_start = do_write && wlane_r && !gain_used_r &&
            (waddr_r == clk_sel_pkg::ADDR_PIN_MODE) &&
            !pin_mode_r[clk_sel_pkg::GAIN_BIT] &&
            wdata_r[clk_sel_pkg::GAIN_BIT] &&
            (cpu_src_r == clk_sel_pkg::CPU_HS_SYSTEM) &&
            wdata_r[clk_sel_pkg::HS_EXT_BIT] && wdata_r[clk_sel_pkg::HS_OSC_BIT];
    end

    // register file next values
    always_comb begin
        pin_mode_nxt = pin_mode_r;
        proc_clk_nxt = proc_clk_r;
        int_osc_nxt = int_osc_r;
        main_osc_nxt = main_osc_r;
        main_mode_nxt = main_mode_r;
        gain_used_nxt = gain_used_r;
        if (do_write && wlane_r) begin
            unique case (waddr_r)
                clk_sel_pkg::ADDR_PIN_MODE: begin
                    // bits 3:1 are never stored
                    pin_mode_nxt = wdata_r & clk_sel_pkg::PIN_MODE_WMASK;
                    if (gain_used_r) begin
                        // gain is frozen after the first write to this register
                        pin_mode_nxt[clk_sel_pkg::GAIN_BIT] =
                            pin_mode_r[clk_sel_pkg::GAIN_BIT];
                    end
                    gain_used_nxt = 1'b1;
                end
                clk_sel_pkg::ADDR_PROC_CLK: begin
                    proc_clk_nxt = wdata_r & clk_sel_pkg::PROC_CLK_WMASK;
                end
                clk_sel_pkg::ADDR_INT_OSC: begin
                    int_osc_nxt = wdata_r & clk_sel_pkg::INT_OSC_WMASK;
                end
                clk_sel_pkg::ADDR_MAIN_OSC: begin
                    main_osc_nxt = wdata_r & clk_sel_pkg::MAIN_OSC_WMASK;
                end
                clk_sel_pkg::ADDR_MAIN_MODE: begin
                    main_mode_nxt = wdata_r & clk_sel_pkg::MAIN_MODE_WMASK;
                end
                default: begin
                    // status and unmapped: nothing stored
                end
            endcase
        end
    end

    // register file flip-flops; reset forces internal clock and port modes
    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            pin_mode_r <= clk_sel_pkg::RST_PIN_MODE;
            proc_clk_r <= clk_sel_pkg::RST_PROC_CLK;
            int_osc_r <= clk_sel_pkg::RST_INT_OSC;
            main_osc_r <= clk_sel_pkg::RST_MAIN_OSC;
            main_mode_r <= clk_sel_pkg::RST_MAIN_MODE;
            gain_used_r <= 1'b0;
        end else begin
            pin_mode_r <= pin_mode_nxt;
            proc_clk_r <= proc_clk_nxt;
            int_osc_r <= int_osc_nxt;
            main_osc_r <= main_osc_nxt;
            main_mode_r <= main_mode_nxt;
            gain_used_r <= gain_used_nxt;
        end
    end

    // cpu source: subsystem, high-speed system or internal; never low-speed
    always_comb begin
        if (proc_clk_r[clk_sel_pkg::CPU_SUB_SEL_BIT]) begin
            cpu_src_nxt = clk_sel_pkg::CPU_SUBSYSTEM;
        end else if (main_mode_r[clk_sel_pkg::MAIN_SEL_HS_BIT]) begin
            cpu_src_nxt = clk_sel_pkg::CPU_HS_SYSTEM;
        end else begin
            cpu_src_nxt = clk_sel_pkg::CPU_HS_INTERNAL;
        end
    end

    // cpu source register; internal high-speed after every reset
    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            cpu_src_r <= clk_sel_pkg::CPU_HS_INTERNAL;
        end else begin
            cpu_src_r <= cpu_src_nxt;
        end
    end

    // oscillator enables
    always_comb begin
        MAIN_XTAL_EN_OUT = (hs_mode == clk_sel_pkg::PIN_RESONATOR) &&
            !main_osc_r[clk_sel_pkg::MAIN_STOP_BIT] && !STOP_MODE_IN;
        HS_INT_OSC_EN_OUT = !int_osc_r[clk_sel_pkg::HS_INT_STOP_BIT] &&
            !STOP_MODE_IN;
        EXT_MAIN_GATE_EN_OUT = (hs_mode == clk_sel_pkg::PIN_EXT_CLOCK) &&
            !int_osc_r[clk_sel_pkg::EXT_MAIN_DIS_BIT] && !STOP_MODE_IN;
        SUB_XTAL_EN_OUT = (sub_mode == clk_sel_pkg::PIN_RESONATOR);
        SUB_EXT_GATE_EN_OUT = (sub_mode == clk_sel_pkg::PIN_EXT_CLOCK);
        LS_OSC_EN_OUT = !ls_stop_ok;
    end

    // pin mode, gain and cpu selection outputs
    assign HS_PIN_MODE_OUT = hs_mode;
    assign SUB_PIN_MODE_OUT = sub_mode;
    assign OSC_GAIN_HIGH_OUT = pin_mode_r[clk_sel_pkg::GAIN_BIT];
    assign CPU_CLK_SRC_OUT = cpu_src_r;
    assign CPU_CLK_DIV_OUT = proc_clk_r[2:0];
    assign CPU_CLK_HOLD_OUT = hold_busy;

    // axi handshakes: one write and one read outstanding
    assign S_AXI_AWREADY_OUT = !aw_held_r && !bvalid_r;
    assign S_AXI_WREADY_OUT = !w_held_r && !bvalid_r;
    assign S_AXI_ARREADY_OUT = !rvalid_r;
    assign S_AXI_BVALID_OUT = bvalid_r;
    assign S_AXI_BRESP_OUT = bresp_r;
    assign S_AXI_RVALID_OUT = rvalid_r;
    assign S_AXI_RDATA_OUT = rdata_r;
    assign S_AXI_RRESP_OUT = rresp_r;

    // write channel: capture address and data in any order, then respond
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        wlane_nxt = wlane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_held_nxt = 1'b1;
            waddr_nxt = S_AXI_AWADDR_IN;
        end
        if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_held_nxt = 1'b1;
            wdata_nxt = S_AXI_WDATA_IN[7:0];
            wlane_nxt = S_AXI_WSTRB_IN[0];
        end
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = addr_mapped(waddr_r) ? clk_sel_pkg::RESP_OKAY : clk_sel_pkg::RESP_SLVERR;
        end else if (bvalid_r && S_AXI_BREADY_IN) begin
            bvalid_nxt = 1'b0;
        end
    end

    // read channel: answer one cycle after the address is taken
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = addr_mapped(S_AXI_ARADDR_IN) ? clk_sel_pkg::RESP_OKAY :
                clk_sel_pkg::RESP_SLVERR;
            rdata_nxt = 32'h0000_0000;
            unique case (S_AXI_ARADDR_IN)
                clk_sel_pkg::ADDR_PIN_MODE: begin
                    rdata_nxt[7:0] = pin_mode_r;
                end
                clk_sel_pkg::ADDR_PROC_CLK: begin
                    rdata_nxt[7:0] = proc_clk_r;
                    rdata_nxt[clk_sel_pkg::CPU_STATUS_BIT] =
                        (cpu_src_r == clk_sel_pkg::CPU_SUBSYSTEM);
                end
                clk_sel_pkg::ADDR_INT_OSC: begin
                    rdata_nxt[7:0] = int_osc_r;
                end
                clk_sel_pkg::ADDR_MAIN_OSC: begin
                    // stop flag gates the main crystal enable
                    rdata_nxt[7:0] = main_osc_r;
                end
                clk_sel_pkg::ADDR_MAIN_MODE: begin
                    rdata_nxt[7:0] = main_mode_r;
                end
                clk_sel_pkg::ADDR_STATUS: begin
                    rdata_nxt[7:0] = {gain_used_r, hold_busy, LS_OSC_EN_OUT,
                        SUB_EXT_GATE_EN_OUT, SUB_XTAL_EN_OUT, EXT_MAIN_GATE_EN_OUT,
                        HS_INT_OSC_EN_OUT, MAIN_XTAL_EN_OUT};
                    rdata_nxt[9:8] = cpu_src_r;
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end else if (rvalid_r && S_AXI_RREADY_IN) begin
            rvalid_nxt = 1'b0;
        end
    end

    // bus registers
    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 8'h00;
            wlane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= clk_sel_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= clk_sel_pkg::RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            wlane_r <= wlane_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end
endmodule
`default_nettype wire

// File: verification/clk_sel_sva.sv
// port checker for the clock source selection unit
`timescale 1ns/1ps
`default_nettype none
module clk_sel_sva #(
    parameter int GAIN_HOLD_EDGES = 160
) (
    input wire logic CLK_SYS_IN,
    input wire logic SRST_IN,
    input wire logic STOP_MODE_IN,
    input wire logic LS_SW_STOP_PERMIT_IN,
    input wire logic S_AXI_BREADY_IN,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic [1:0] S_AXI_BRESP_OUT,
    input wire logic MAIN_XTAL_EN_OUT,
    input wire logic HS_INT_OSC_EN_OUT,
    input wire logic EXT_MAIN_GATE_EN_OUT,
    input wire logic SUB_XTAL_EN_OUT,
    input wire logic SUB_EXT_GATE_EN_OUT,
    input wire logic LS_OSC_EN_OUT,
    input wire logic [1:0] HS_PIN_MODE_OUT,
    input wire logic [1:0] SUB_PIN_MODE_OUT,
    input wire logic [1:0] CPU_CLK_SRC_OUT,
    input wire logic CPU_CLK_HOLD_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (SRST_IN);
    logic [15:0] hcnt_r; // cycles the cpu clock has been held
    logic [15:0] hcnt_nxt;
    // count while held, restart on release
    always_comb hcnt_nxt = CPU_CLK_HOLD_OUT ? hcnt_r + 16'h0001 : 16'h0000;
    always_ff @(posedge CLK_SYS_IN) hcnt_r <= SRST_IN ? 16'h0000 : hcnt_nxt;
    reset_src_a: assert property ($fell(SRST_IN) |-> CPU_CLK_SRC_OUT == 2'b00)
        else $error("cpu not on internal clock after reset");
    main_xtal_a: assert property (MAIN_XTAL_EN_OUT |-> HS_PIN_MODE_OUT == 2'b01 && !STOP_MODE_IN)
        else $error("main crystal runs when it must stop");
    hs_int_a: assert property (STOP_MODE_IN |-> !HS_INT_OSC_EN_OUT)
        else $error("internal oscillator runs in stop");
    ext_gate_a: assert property (EXT_MAIN_GATE_EN_OUT |-> HS_PIN_MODE_OUT == 2'b11 && !STOP_MODE_IN)
        else $error("external clock gate open wrongly");
    sub_xtal_a: assert property (SUB_XTAL_EN_OUT == (SUB_PIN_MODE_OUT == 2'b01))
        else $error("sub crystal enable disagrees with mode");
    sub_ext_a: assert property (SUB_EXT_GATE_EN_OUT == (SUB_PIN_MODE_OUT == 2'b11))
        else $error("sub external gate disagrees with mode");
    ls_keep_a: assert property (!LS_SW_STOP_PERMIT_IN |-> LS_OSC_EN_OUT)
        else $error("low-speed oscillator stopped without permission");
    cpu_src_a: assert property (CPU_CLK_SRC_OUT != 2'b11)
        else $error("illegal cpu clock source");
    hs_mode_a: assert property (HS_PIN_MODE_OUT != 2'b10)
        else $error("illegal high-speed pin mode");
    hold_src_a: assert property ($rose(CPU_CLK_HOLD_OUT) |-> CPU_CLK_SRC_OUT == 2'b01)
        else $error("cpu hold without external clock source");
    hold_len_a: assert property ($fell(CPU_CLK_HOLD_OUT) |-> hcnt_r >= GAIN_HOLD_EDGES)
        else $error("cpu hold too short");
    bresp_hold_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
        S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("write response dropped");
    hold_c: cover property ($rose(CPU_CLK_HOLD_OUT));
    xtal_c: cover property (MAIN_XTAL_EN_OUT);
    gate_c: cover property (EXT_MAIN_GATE_EN_OUT);
    ls_off_c: cover property (!LS_OSC_EN_OUT);
endmodule
bind clock_source_select_unit clk_sel_sva #(.GAIN_HOLD_EDGES(GAIN_HOLD_EDGES)) u_sva (.*);
`default_nettype wire

// File: verification/clk_far_model.sv
// far side: an external high-speed clock source, still unless asked to run
`timescale 1ns/1ps
`default_nettype none
module clk_far_model #(
    parameter int HALF_NS = 61
) (
    input wire logic run_in,
    output logic ext_clk_out
);
    initial ext_clk_out = 1'b0;
    // toggles off the system clock's phase; parks low when stopped
    always begin
        #(HALF_NS);
        ext_clk_out = run_in ? ~ext_clk_out : 1'b0;
    end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench of the clock source selection unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0;
    logic rre = 1'b0, stp = 1'b0, perm = 1'b0, erun = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, d;
    logic [3:0] wstb = 4'hF;
    logic ext, awr, wrd, bv, arr, rv, mx, hi, eg, sx, se, ls, gain, hold;
    logic [1:0] brsp, rrsp, hpm, spm, src, r, em;
    logic [2:0] div;
    int n_mismatch = 0, samples_checked = 0, n;
    always #12.5 clk = ~clk;
    clock_source_select_unit #(.GAIN_HOLD_EDGES(4)) u_dut (.CLK_SYS_IN(clk), .SRST_IN(rst),
        .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(awa),
        .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd), .S_AXI_WDATA_IN(wdat),
        .S_AXI_WSTRB_IN(wstb), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bre),
        .S_AXI_BRESP_OUT(brsp), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
        .S_AXI_ARADDR_IN(ara), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rre),
        .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rrsp), .STOP_MODE_IN(stp),
        .LS_SW_STOP_PERMIT_IN(perm), .EXT_MAIN_CLK_IN(ext), .MAIN_XTAL_EN_OUT(mx),
        .HS_INT_OSC_EN_OUT(hi), .EXT_MAIN_GATE_EN_OUT(eg), .SUB_XTAL_EN_OUT(sx),
        .SUB_EXT_GATE_EN_OUT(se), .LS_OSC_EN_OUT(ls), .HS_PIN_MODE_OUT(hpm),
        .SUB_PIN_MODE_OUT(spm), .OSC_GAIN_HIGH_OUT(gain), .CPU_CLK_SRC_OUT(src),
        .CPU_CLK_DIV_OUT(div), .CPU_CLK_HOLD_OUT(hold));
    clk_far_model u_far (.run_in(erun), .ext_clk_out(ext));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset;
        if (!rst) @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
    endtask
    // axi write: handshakes judged at the negedge before the sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic ta, tw, tb = 1'b0;
        @(posedge clk);
        {awv, wv, bre} <= 3'b111;
        awa <= a;
        wdat <= {24'h0, v};
        while (!tb) begin
            @(negedge clk);
            {ta, tw, tb, r} = {awv && awr, wv && wrd, bv, brsp};
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        bre <= 1'b0;
        @(negedge clk);
        chk(bv, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, tb = 1'b0;
        @(posedge clk);
        {arv, rre} <= 2'b11;
        ara <= a;
        while (!tb) begin
            @(negedge clk);
            {ta, tb, d, r} = {arv && arr, rv, rdat, rrsp};
            @(posedge clk);
            if (ta) arv <= 1'b0;
        end
        rre <= 1'b0;
        @(negedge clk);
        chk(rv, 1'b0);
    endtask
    task automatic t_reset;
        chk(src, 2'b00);
        chk({hi, ls, mx, hpm, div}, 8'hC1);
        rd(clk_sel_pkg::ADDR_PIN_MODE);
        chk(d, 32'h0);
    endtask
    // gain raised under external clock halts the cpu, then sticks
    task automatic t_gain;
        wr(clk_sel_pkg::ADDR_MAIN_MODE, 8'h01);
        chk(src, 2'b01);
        erun = 1'b1;
        wr(clk_sel_pkg::ADDR_PIN_MODE, 8'hC1);
        chk(eg, 1'b1);
        for (n = 0; n < 20 && hold !== 1'b1; n++) @(negedge clk);
        chk(hold, 1'b1);
        for (n = 0; n < 400 && hold !== 1'b0; n++) @(negedge clk);
        chk({hold, gain}, 2'b01);
        wr(clk_sel_pkg::ADDR_PIN_MODE, 8'hC0);
        chk(gain, 1'b1);
        erun = 1'b0;
    endtask
    task automatic t_hs;
        // every high-speed pin mode is tried while the main stop flag is still set
        for (int i = 0; i < 4; i++) begin
            wr(clk_sel_pkg::ADDR_PIN_MODE, {i[1:0], 6'h0E});
            em = (i == 2) ? 2'b00 : i[1:0];
            chk({hpm, mx, eg}, {em, 1'b0, em == 2'b11});
            rd(clk_sel_pkg::ADDR_PIN_MODE);
            chk(d, {24'h0, i[1:0], 6'h00});
        end
        @(posedge clk) stp <= 1'b1;
        @(negedge clk);
        chk({eg, hi}, 2'b00);
        @(posedge clk) stp <= 1'b0;
        wr(clk_sel_pkg::ADDR_INT_OSC, 8'h05);
        chk({eg, hi}, 2'b00);
        wr(clk_sel_pkg::ADDR_PIN_MODE, 8'h40);
        wr(clk_sel_pkg::ADDR_MAIN_OSC, 8'h00);
        chk(mx, 1'b1);
        @(posedge clk) stp <= 1'b1;
        @(negedge clk);
        chk(mx, 1'b0);
        @(posedge clk) stp <= 1'b0;
        wr(clk_sel_pkg::ADDR_MAIN_OSC, 8'h80);
        chk(mx, 1'b0);
    endtask
    // every start bit and sub mode pair
    task automatic t_sub;
        for (int i = 0; i < 8; i++) begin
            wr(clk_sel_pkg::ADDR_PROC_CLK, {1'b0, i[2], 6'h01});
            wr(clk_sel_pkg::ADDR_PIN_MODE, {2'b00, i[1:0], 4'h0});
            em = (i[2] || i[1:0] == 2'b01) ? 2'b01 : (i[1:0] == 2'b11 ? 2'b11 : 2'b00);
            chk({spm, sx, se}, {em, em == 2'b01, em == 2'b11});
        end
    endtask
    task automatic t_ls_bad;
        wr(clk_sel_pkg::ADDR_INT_OSC, 8'h02);
        chk(ls, 1'b1);
        @(posedge clk) perm <= 1'b1;
        @(negedge clk);
        chk(ls, 1'b0);
        wr(8'h20, 8'h55);
        chk(r, clk_sel_pkg::RESP_SLVERR);
        rd(8'h20);
        chk(r, clk_sel_pkg::RESP_SLVERR);
        chk(d, 32'h0);
    endtask
    initial begin
        do_reset();
        t_reset();
        t_gain();
        do_reset();
        t_hs();
        do_reset();
        t_sub();
        t_ls_bad();
        summarize();
    end
    // watchdog well beyond the expected run
    initial begin
        #1000000;
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
